// ==== src/pss_sram_port.sv ====
`timescale 1ns/100ps

// Overview of operation
// - Load-advance low loads address, high bursts
// - All inputs registered except clock enable, write data, output enable, strap
// - Clock enable high freezes whole state
// - Low two address bits preset burst counter
// - Chip enabled only on 0/1/0; else deselect
// - Enabled, strobe low, load: new write
// - Enabled, strobe high, load: new read
// - New write uses byte enables of load cycle
// - Burst cycle ignores chip enables, strobe, address
// - Burst continues previous write, read or deselect
// - Write without byte enables still loads, advances
// - Only bytes with low enable are written
// - Reads return all bytes, enables ignored
// - Two bytes, each with own write enable
// - Linear order counts low bits modulo four
// - Interleaved order XORs start with count
module pss_sram_port (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clockEnN,
   input wire logic [pss_pkg::HI_W-1:0] addrIn,
   input wire logic [pss_pkg::CNT_W-1:0] burstStartBits,
   input wire logic chipEnPrimaryN,
   input wire logic chipEnDepthHi,
   input wire logic chipEnDepthLoN,
   input wire logic writeStrobeN,
   input wire logic [pss_pkg::NUM_BYTES-1:0] byteWriteN,
   input wire logic loadAdvance,
   input wire logic burstOrderStrap,
   input wire logic outEnN,
   input wire logic [pss_pkg::DATA_W-1:0] dataLaneIn,
   output logic [pss_pkg::DATA_W-1:0] dataLaneOut,
   output logic dataLaneOe
);

   // ==================================================================
   // Declarations
   logic advance;

   logic advQ;
   logic advD;
   logic enQ;
   logic enD;
   logic wrNQ;
   logic wrND;
   logic [pss_pkg::NUM_BYTES-1:0] bweQ;
   logic [pss_pkg::NUM_BYTES-1:0] bweD;
   logic [pss_pkg::HI_W-1:0] hiInQ;
   logic [pss_pkg::HI_W-1:0] hiInD;
   logic [pss_pkg::CNT_W-1:0] startInQ;
   logic [pss_pkg::CNT_W-1:0] startInD;

   pss_pkg::pss_op_e lastOpQ;
   pss_pkg::pss_op_e lastOpD;
   pss_pkg::pss_op_e op;
   logic load;
   logic step;
   logic [pss_pkg::HI_W-1:0] hiAddrQ;
   logic [pss_pkg::HI_W-1:0] hiAddrD;
   logic [pss_pkg::CNT_W-1:0] burstBits;
   logic [pss_pkg::ADDR_W-1:0] accAddr;

   logic wrPendQ;
   logic wrPendD;
   logic [pss_pkg::ADDR_W-1:0] wrAddrQ;
   logic [pss_pkg::ADDR_W-1:0] wrAddrD;
   logic [pss_pkg::NUM_BYTES-1:0] wrBweQ;
   logic [pss_pkg::NUM_BYTES-1:0] wrBweD;

   logic [pss_pkg::DATA_W-1:0] mem [pss_pkg::MEM_DEPTH];
   logic [pss_pkg::DATA_W-1:0] oldWord;
   logic [pss_pkg::DATA_W-1:0] wrWord;
   logic [pss_pkg::DATA_W-1:0] rdRaw;
   logic [pss_pkg::DATA_W-1:0] rdWord;
   logic fwdHit;

   logic bufInValid;
   logic bufInReady;
   logic bufOutValid;
   logic bufOutReady;
   logic [pss_pkg::DATA_W-1:0] bufOutData;

   logic [pss_pkg::DATA_W-1:0] doutQ;
   logic [pss_pkg::DATA_W-1:0] doutD;
   logic driveQ;
   logic driveD;

   // Clock enable is active low; every state group holds without it
   assign advance = !clockEnN;

   // ==================================================================
   // Input capture stage
   always_comb begin
      advD = advQ;
      enD = enQ;
      wrND = wrNQ;
      bweD = bweQ;
      hiInD = hiInQ;
      startInD = startInQ;
      if (advance) begin
         advD = loadAdvance;
         enD = !chipEnPrimaryN && chipEnDepthHi && !chipEnDepthLoN;
         wrND = writeStrobeN;
         bweD = byteWriteN;
         hiInD = addrIn;
         startInD = burstStartBits;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         advQ <= 1'b0;
         enQ <= 1'b0;
         wrNQ <= 1'b1;
         bweQ <= pss_pkg::BWE_RESET;
         hiInQ <= pss_pkg::HI_RESET;
         startInQ <= pss_pkg::CNT_RESET;
      end else begin
         advQ <= advD;
         enQ <= enD;
         wrNQ <= wrND;
         bweQ <= bweD;
         hiInQ <= hiInD;
         startInQ <= startInD;
      end
   end

   // ==================================================================
   // Command decode and address stage
   always_comb begin
      op = pss_pkg::PSS_DESEL;
      load = 1'b0;
      if (advQ) begin
         op = lastOpQ;
      end else if (enQ) begin
         load = 1'b1;
         op = wrNQ ? pss_pkg::PSS_READ : pss_pkg::PSS_WRITE;
      end
      step = advQ && (lastOpQ != pss_pkg::PSS_DESEL);
      lastOpD = advance ? op : lastOpQ;
      hiAddrD = hiAddrQ;
      if (advance && load) begin
         hiAddrD = hiInQ;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lastOpQ <= pss_pkg::PSS_DESEL;
         hiAddrQ <= pss_pkg::HI_RESET;
      end else begin
         lastOpQ <= lastOpD;
         hiAddrQ <= hiAddrD;
      end
   end

   pss_burst_ctr u_burst (
      .clk_sys(clk_sys),
      .rst(rst),
      .hold(clockEnN),
      .load(load),
      .step(step),
      .startBits(startInQ),
      .interleave(burstOrderStrap),
      .burstBits(burstBits)
   );

   assign accAddr = {hiAddrD, burstBits};

   // ==================================================================
   // Write pending stage: data arrives one enabled edge later
   always_comb begin
      wrPendD = wrPendQ;
      wrAddrD = wrAddrQ;
      wrBweD = wrBweQ;
      if (advance) begin
         wrPendD = (op == pss_pkg::PSS_WRITE);
         wrAddrD = accAddr;
         wrBweD = bweQ;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrPendQ <= 1'b0;
         wrAddrQ <= '0;
         wrBweQ <= pss_pkg::BWE_RESET;
      end else begin
         wrPendQ <= wrPendD;
         wrAddrQ <= wrAddrD;
         wrBweQ <= wrBweD;
      end
   end

   // ==================================================================
   // Array, byte merge and read forwarding
   // A read issued right after a write to the same word sees the
   // write, since both touch the array on the same edge.
   assign oldWord = mem[wrAddrQ];
   assign rdRaw = mem[accAddr];
   assign fwdHit = wrPendQ && (wrAddrQ == accAddr);

   for (genvar i = 0; i < pss_pkg::NUM_BYTES; i++) begin : g_lane
      localparam int Lsb = i * pss_pkg::BYTE_W;
      assign wrWord[Lsb +: pss_pkg::BYTE_W] = wrBweQ[i] ?
         oldWord[Lsb +: pss_pkg::BYTE_W] : dataLaneIn[Lsb +: pss_pkg::BYTE_W];
      assign rdWord[Lsb +: pss_pkg::BYTE_W] = (fwdHit && !wrBweQ[i]) ?
         dataLaneIn[Lsb +: pss_pkg::BYTE_W] : rdRaw[Lsb +: pss_pkg::BYTE_W];
   end

   // A write with every byte masked still rewrites old contents
   always_ff @(posedge clk_sys) begin
      if (advance && wrPendQ) begin
         mem[wrAddrQ] <= wrWord;
      end
   end

   // ==================================================================
   // Read path: buffer between array access and output register
   assign bufInValid = advance && (op == pss_pkg::PSS_READ);
   assign bufOutReady = advance;

   pss_pair_buf u_rdbuf (
      .clk_sys(clk_sys),
      .rst(rst),
      .inValid(bufInValid),
      .inReady(bufInReady),
      .inData(rdWord),
      .outValid(bufOutValid),
      .outReady(bufOutReady),
      .outData(bufOutData)
   );

   // ==================================================================
   // Output register
   always_comb begin
      doutD = doutQ;
      driveD = driveQ;
      if (advance) begin
         driveD = bufOutValid;
         if (bufOutValid) begin
            doutD = bufOutData;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         doutQ <= pss_pkg::DATA_RESET;
         driveQ <= 1'b0;
      end else begin
         doutQ <= doutD;
         driveQ <= driveD;
      end
   end

   assign dataLaneOut = doutQ;
   // Output enable gates the drivers without waiting for a clock
   assign dataLaneOe = driveQ && !outEnN;

endmodule

// ==== src/pss_pkg.sv ====
package pss_pkg;

   // ==================================================================
   // Geometry: 256K words of two 9-bit bytes
   localparam int ADDR_W = 18;
   localparam int HI_W = 16;
   localparam int CNT_W = 2;
   localparam int DATA_W = 18;
   localparam int BYTE_W = 9;
   localparam int NUM_BYTES = 2;
   localparam int MEM_DEPTH = 262144;

   // ==================================================================
   // Byte lane positions within a word
   localparam int BYTE_A_LSB = 0;
   localparam int BYTE_B_LSB = 9;

   // ==================================================================
   // Buffer geometry
   localparam int BUF_DEPTH = 2;
   localparam int BUF_PTR_W = 1;
   localparam int BUF_CNT_W = 2;

   // ==================================================================
   // Reset values and counter step
   localparam logic [CNT_W-1:0] CNT_RESET = 2'h0;
   localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
   localparam logic [HI_W-1:0] HI_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;
   localparam logic [NUM_BYTES-1:0] BWE_RESET = 2'h3;

   // ==================================================================
   // Clock: 50 MHz
   localparam int CLK_PERIOD_NS = 20;
   // Read data appears this many enabled edges after the command edge
   localparam int READ_LATENCY = 2;

   // ==================================================================
   // Operation carried from one cycle to the next
   typedef enum logic [1:0] {
      PSS_DESEL,
      PSS_READ,
      PSS_WRITE
   } pss_op_e;

endpackage

// ==== src/pss_burst_ctr.sv ====
`timescale 1ns/100ps

module pss_burst_ctr (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hold,
   input wire logic load,
   input wire logic step,
   input wire logic [pss_pkg::CNT_W-1:0] startBits,
   input wire logic interleave,
   output logic [pss_pkg::CNT_W-1:0] burstBits
);

   logic [pss_pkg::CNT_W-1:0] startQ;
   logic [pss_pkg::CNT_W-1:0] startD;
   logic [pss_pkg::CNT_W-1:0] cntQ;
   logic [pss_pkg::CNT_W-1:0] cntD;

   // ==================================================================
   // Counter state
   always_comb begin
      startD = startQ;
      cntD = cntQ;
      if (!hold) begin
         if (load) begin
            startD = startBits;
            cntD = pss_pkg::CNT_RESET;
         end else if (step) begin
            cntD = cntQ + pss_pkg::CNT_STEP;
         end
      end
      // Strap is read live, never registered
      if (interleave) begin
         burstBits = startD ^ cntD;
      end else begin
         burstBits = startD + cntD;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         startQ <= pss_pkg::CNT_RESET;
         cntQ <= pss_pkg::CNT_RESET;
      end else begin
         startQ <= startD;
         cntQ <= cntD;
      end
   end

endmodule

// ==== src/pss_pair_buf.sv ====
`timescale 1ns/100ps

module pss_pair_buf (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [pss_pkg::DATA_W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [pss_pkg::DATA_W-1:0] outData
);

   logic [pss_pkg::DATA_W-1:0] slotQ [pss_pkg::BUF_DEPTH];
   logic [pss_pkg::BUF_PTR_W-1:0] wrPtrQ;
   logic [pss_pkg::BUF_PTR_W-1:0] wrPtrD;
   logic [pss_pkg::BUF_PTR_W-1:0] rdPtrQ;
   logic [pss_pkg::BUF_PTR_W-1:0] rdPtrD;
   logic [pss_pkg::BUF_CNT_W-1:0] cntQ;
   logic [pss_pkg::BUF_CNT_W-1:0] cntD;
   logic push;
   logic pop;

   // ==================================================================
   // Pointers and fill level
   always_comb begin
      inReady = (cntQ != pss_pkg::BUF_CNT_W'(pss_pkg::BUF_DEPTH));
      outValid = (cntQ != '0);
      outData = slotQ[rdPtrQ];
      push = inValid && inReady;
      pop = outValid && outReady;
      wrPtrD = push ? wrPtrQ + 1'b1 : wrPtrQ;
      rdPtrD = pop ? rdPtrQ + 1'b1 : rdPtrQ;
      cntD = cntQ;
      if (push && !pop) begin
         cntD = cntQ + 2'h1;
      end else if (pop && !push) begin
         cntD = cntQ - 2'h1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrPtrQ <= '0;
         rdPtrQ <= '0;
         cntQ <= '0;
      end else begin
         wrPtrQ <= wrPtrD;
         rdPtrQ <= rdPtrD;
         cntQ <= cntD;
      end
   end

   // Storage needs no reset; fill level guards it
   always_ff @(posedge clk_sys) begin
      if (push) begin
         slotQ[wrPtrQ] <= inData;
      end
   end

endmodule

// ==== dv/pss_sram_port_sva.sv ====
`timescale 1ns/100ps

// ==================================================================
// Port checker: drive timing seen from the command pins
module pss_sram_port_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clockEnN,
   input wire logic chipEnPrimaryN,
   input wire logic chipEnDepthHi,
   input wire logic chipEnDepthLoN,
   input wire logic writeStrobeN,
   input wire logic loadAdvance,
   input wire logic outEnN,
   input wire logic [pss_pkg::DATA_W-1:0] dataLaneOut,
   input wire logic dataLaneOe
);
   logic chipEn, rdCmd, wrCmd, dsCmd, bstCmd;
   assign chipEn = !chipEnPrimaryN && chipEnDepthHi && !chipEnDepthLoN;
   assign rdCmd = !clockEnN && !loadAdvance && chipEn && writeStrobeN;
   assign wrCmd = !clockEnN && !loadAdvance && chipEn && !writeStrobeN;
   assign dsCmd = !clockEnN && !loadAdvance && !chipEn;
   assign bstCmd = !clockEnN && loadAdvance;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Two further enabled edges bring a command to the output register
   sequence twoOn;
      !clockEnN [*2];
   endsequence
   AST_OE_NEEDS_ENABLE: assert property (dataLaneOe |-> !outEnN)
      else $error("bus driven while output enable is off");
   AST_FREEZE_DATA: assert property (clockEnN |=> $stable(dataLaneOut))
      else $error("read word moved on a disabled edge");
   AST_FREEZE_DRIVE: assert property (
      (clockEnN && !outEnN) ##1 !outEnN |-> $stable(dataLaneOe))
      else $error("drive moved on a disabled edge");
   AST_READ_DRIVES: assert property (rdCmd ##1 twoOn |=> dataLaneOe || outEnN)
      else $error("read did not drive the bus");
   AST_WRITE_NO_DRIVE: assert property (wrCmd ##1 twoOn |=> !dataLaneOe)
      else $error("bus driven in a write data slot");
   AST_DESEL_NO_DRIVE: assert property (dsCmd ##1 twoOn |=> !dataLaneOe)
      else $error("deselect drove the bus");
   AST_BURST_DESEL: assert property (dsCmd ##1 bstCmd ##1 twoOn |=> !dataLaneOe)
      else $error("burst after deselect drove the bus");
   AST_BURST_READ: assert property (rdCmd ##1 bstCmd ##1 twoOn |=> dataLaneOe || outEnN)
      else $error("burst read did not drive the bus");
   AST_RESET_IDLE: assert property (
      disable iff (1'b0) rst |-> !dataLaneOe && dataLaneOut == pss_pkg::DATA_RESET)
      else $error("outputs not idle in reset");
   cover property (rdCmd ##1 bstCmd);
   cover property (wrCmd ##1 bstCmd);
   cover property (clockEnN ##1 clockEnN);
endmodule

bind pss_sram_port pss_sram_port_chk i_pss_sram_port_chk (.clk_sys(clk_sys), .rst(rst),
   .clockEnN(clockEnN), .chipEnPrimaryN(chipEnPrimaryN), .chipEnDepthHi(chipEnDepthHi),
   .chipEnDepthLoN(chipEnDepthLoN), .writeStrobeN(writeStrobeN), .loadAdvance(loadAdvance),
   .outEnN(outEnN), .dataLaneOut(dataLaneOut), .dataLaneOe(dataLaneOe));

// ==== dv/pss_ctrl_model.sv ====
`timescale 1ns/100ps

// ==================================================================
// Controller data side: write word follows its command by two enabled edges
module pss_ctrl_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clockEnN,
   input wire logic loadAdvance,
   input wire logic writeStrobeN,
   input wire logic chipEn,
   input wire logic [pss_pkg::DATA_W-1:0] wrData,
   output logic [pss_pkg::DATA_W-1:0] dataLaneIn
);
   logic wr1_q, wr2_q, wrNow;
   logic [pss_pkg::DATA_W-1:0] d1_q, d2_q;
   assign wrNow = loadAdvance ? wr1_q : (chipEn && !writeStrobeN);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr1_q <= 1'b0;
         wr2_q <= 1'b0;
         d1_q <= 18'h00000;
         d2_q <= 18'h00000;
      end else if (!clockEnN) begin
         wr1_q <= wrNow;
         wr2_q <= wr1_q;
         d1_q <= wrData;
         d2_q <= d1_q;
      end
   end
   // Released bus shows a stale inverted word, so a late sample cannot match
   assign dataLaneIn = wr2_q ? d2_q : ~d2_q;
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps

// ==================================================================
// Self-checking bench with a byte-level reference of eight words
module tb_top;
   logic clk_sys, rst, clockEnN, chipEnPrimaryN, chipEnDepthHi, chipEnDepthLoN;
   logic writeStrobeN, loadAdvance, burstOrderStrap, outEnN, chipEn, dataLaneOe, hi;
   logic [15:0] addrIn;
   logic [1:0] burstStartBits, byteWriteN, k, s;
   logic [pss_pkg::DATA_W-1:0] dataLaneIn, dataLaneOut, wrData;
   logic [pss_pkg::DATA_W-1:0] mem [8];
   logic [pss_pkg::DATA_W-1:0] expQ [$];
   logic [31:0] r;
   logic [2:0] rdPipe;
   pss_pkg::pss_op_e op;
   int n_errors, checks_done, cycles, i;
   integer seed;

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   assign chipEn = !chipEnPrimaryN && chipEnDepthHi && !chipEnDepthLoN;

   pss_sram_port i_pss_sram_port (.clk_sys(clk_sys), .rst(rst), .clockEnN(clockEnN),
      .addrIn(addrIn), .burstStartBits(burstStartBits), .chipEnPrimaryN(chipEnPrimaryN),
      .chipEnDepthHi(chipEnDepthHi), .chipEnDepthLoN(chipEnDepthLoN),
      .writeStrobeN(writeStrobeN), .byteWriteN(byteWriteN), .loadAdvance(loadAdvance),
      .burstOrderStrap(burstOrderStrap), .outEnN(outEnN), .dataLaneIn(dataLaneIn),
      .dataLaneOut(dataLaneOut), .dataLaneOe(dataLaneOe));
   pss_ctrl_model i_pss_ctrl_model (.clk_sys(clk_sys), .rst(rst), .clockEnN(clockEnN),
      .loadAdvance(loadAdvance), .writeStrobeN(writeStrobeN), .chipEn(chipEn),
      .wrData(wrData), .dataLaneIn(dataLaneIn));

   task automatic complete_run();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check_word(input logic [17:0] got, input logic [17:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t read word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_drive(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t bus drive %b expected %b", $time, got, exp);
      end
   endtask

   task automatic check_empty();
      checks_done++;
      if (expQ.size() != 0) begin
         n_errors++;
         $display("MISMATCH %0t %0d reads never returned", $time, expQ.size());
      end
   endtask

   // Bit map of c: 0 clock off, 1 advance, 2 strobe, 5:3 enables, 7:6 bytes, 9:8 start
   task automatic drive(input logic [31:0] c, input logic [17:0] d);
      logic [2:0] a;
      @(posedge clk_sys);
      clockEnN <= c[0];
      loadAdvance <= c[1];
      writeStrobeN <= c[2];
      chipEnPrimaryN <= c[3];
      chipEnDepthHi <= c[4];
      chipEnDepthLoN <= c[5];
      byteWriteN <= c[7:6];
      burstStartBits <= c[9:8];
      addrIn <= c[1] ? c[25:10] : {15'h0000, c[10]};
      wrData <= d;
      outEnN <= c[28] & c[29] & c[30];
      if (c[0])
         return;
      if (!c[1]) begin
         op = c[2] ? pss_pkg::PSS_READ : pss_pkg::PSS_WRITE;
         if (c[5:3] != 3'h2)
            op = pss_pkg::PSS_DESEL;
         hi = c[10];
         s = c[9:8];
         k = 2'h0;
      end else begin
         k = k + 2'h1;
      end
      a = {hi, burstOrderStrap ? (s ^ k) : (s + k)};
      if (op == pss_pkg::PSS_WRITE) begin
         if (!c[6])
            mem[a][8:0] = d[8:0];
         if (!c[7])
            mem[a][17:9] = d[17:9];
      end
      if (op == pss_pkg::PSS_READ)
         expQ.push_back(mem[a]);
   endtask

   // Sampled between edges; bit 2 marks a read word standing for the coming enabled edge
   always @(negedge clk_sys) begin
      if (rst) begin
         rdPipe <= 3'h0;
      end else if (!clockEnN) begin
         if (rdPipe[2]) begin
            if (expQ.size() == 0) begin
               n_errors++;
               $display("MISMATCH %0t read slot with no expected word", $time);
            end else begin
               check_word(dataLaneOut, expQ.pop_front());
            end
            check_drive(dataLaneOe, !outEnN);
         end else begin
            check_drive(dataLaneOe, 1'b0);
         end
         rdPipe <= {rdPipe[1:0], loadAdvance ? rdPipe[0] : (chipEn && writeStrobeN)};
      end
   end

   // Whole run is about 650 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         $display("MISMATCH %0t run too long", $time);
         complete_run();
      end
   end

   initial begin
      seed = 32'h8bdd65c6;
      rst = 1'b1;
      {clockEnN, chipEnPrimaryN, writeStrobeN, loadAdvance} = 4'hf;
      {chipEnDepthHi, chipEnDepthLoN, burstOrderStrap, outEnN} = 4'h0;
      addrIn = 16'h0000;
      burstStartBits = 2'h0;
      byteWriteN = 2'h3;
      wrData = 18'h00000;
      op = pss_pkg::PSS_DESEL;
      {hi, k, s} = 5'h00;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      for (i = 0; i < 8; i++)
         drive(((i % 4 == 0) ? 32'h10 : 32'h12) | 32'((i / 4) << 10), 18'($random(seed)));
      repeat (2) begin
         repeat (300) begin
            r = $random(seed);
            r[0] = r[0] & r[11] & r[12];
            r[3] = r[3] & r[13];
            r[4] = r[4] | r[14];
            r[5] = r[5] & r[15];
            drive(r, 18'($random(seed)));
         end
         repeat (6) drive(32'h08, 18'h00000);
         check_empty();
         @(posedge clk_sys);
         rst <= 1'b1;
         burstOrderStrap <= 1'b1;
         @(posedge clk_sys);
         rst <= 1'b0;
         op = pss_pkg::PSS_DESEL;
      end
      complete_run();
   end
endmodule
